// ### machine_check_stop_control.sv
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
module machine_check_stop_control (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Error sources and program load
    input mc_pkg::errors_t err,
    input wire logic initialProgramLoad,
    // Processor fetch steering
    input wire logic fetchReq,
    output logic fetchToCache,
    output logic fetchToMain,
    // Machine check results
    output logic hardStop,
    output logic retryEnable,
    output logic channelLogoutEnable,
    output logic mcSoft,
    output logic mcHard,
    output logic logoutReq,
    output logic [31:0] logoutAddr,
    output logic irq
);

    mc_pkg::state_t s_q;
    mc_pkg::state_t s_d;
    logic sysDamage;
    logic softRecov;
    logic softExt;
    logic stopHit;
    logic addrTaken;

    // Error classification
    assign sysDamage = err.cpuUnretryable | err.storageMultiBit | err.keyFail
        | (err.cpuError & ~s_q.ctl[mc_pkg::CTL_RETRY]);
    // Correction reports can be silenced alone; the recovery mask silences both
    assign softRecov = s_q.ctl[mc_pkg::CTL_RECOV]
        & ((err.retryOk & s_q.ctl[mc_pkg::CTL_RETRY])
        | (err.corrected & ~s_q.mode[mc_pkg::MODE_QUIET_CORR]));
    assign softExt = s_q.pswMc & s_q.ctl[mc_pkg::CTL_EXTDMG]
        & (err.todDamage | err.ioMultiBit);
    // No meaningful status can be presented: masked, or a check still in hand
    assign stopHit = sysDamage & s_q.ctl[mc_pkg::CTL_HSTOP]
        & (~s_q.pswMc | s_q.busy);
    assign addrTaken = hsel & htrans[1] & hready;

    // Next state: bus access first, then events, so a set beats a clear
    always_comb begin
        s_d = s_q;
        s_d.logoutReq = 1'b0;
        s_d.mcSoft = 1'b0;
        s_d.mcHard = 1'b0;
        if (s_q.busPhase == mc_pkg::BUS_WAIT) begin
            s_d.busPhase = mc_pkg::BUS_IDLE;
            s_d.rdata = 32'h0;
            if (!s_q.busWrite) begin
                case (s_q.busAddr)
                    mc_pkg::OFF_CTL14: begin
                        s_d.rdata = {26'h0, s_q.ctl};
                    end
                    mc_pkg::OFF_CTL15: begin
                        s_d.rdata = s_q.logBase;
                    end
                    mc_pkg::OFF_PSW: begin
                        s_d.rdata[mc_pkg::PSW_MC_BIT] = s_q.pswMc;
                    end
                    mc_pkg::OFF_MODE: begin
                        s_d.rdata = {30'h0, s_q.mode};
                    end
                    mc_pkg::OFF_CODE: begin
                        s_d.rdata = s_q.code;
                    end
                    mc_pkg::OFF_STAT: begin
                        s_d.rdata[mc_pkg::STAT_STOP] = s_q.stop;
                        s_d.rdata[mc_pkg::STAT_BUSY] = s_q.busy;
                        s_d.rdata[mc_pkg::STAT_BYPASS] = s_q.mode[mc_pkg::MODE_CACHE_OFF];
                    end
                    mc_pkg::OFF_IRQ_STAT: begin
                        s_d.rdata = {29'h0, s_q.irqStat};
                    end
                    mc_pkg::OFF_IRQ_EN: begin
                        s_d.rdata = {29'h0, s_q.irqEn};
                    end
                    default: begin
                        s_d.rdata = 32'h0;
                    end
                endcase
            end else if (!s_q.stop) begin
                // A stopped machine takes no writes; status stays readable
                case (s_q.busAddr)
                    mc_pkg::OFF_CTL14: begin
                        s_d.ctl = hwdata[mc_pkg::CTL_W-1:0];
                    end
                    mc_pkg::OFF_CTL15: begin
                        s_d.logBase = hwdata;
                    end
                    mc_pkg::OFF_PSW: begin
                        s_d.pswMc = hwdata[mc_pkg::PSW_MC_BIT];
                    end
                    mc_pkg::OFF_MODE: begin
                        s_d.mode = hwdata[1:0];
                    end
                    mc_pkg::OFF_CODE: begin
                        // Handler done: release the code and the busy mark
                        s_d.code = 32'h0;
                        s_d.busy = 1'b0;
                    end
                    mc_pkg::OFF_IRQ_EN: begin
                        s_d.irqEn = hwdata[mc_pkg::IRQ_W-1:0];
                    end
                    mc_pkg::OFF_IRQ_CLR: begin
                        s_d.irqStat = s_q.irqStat & ~hwdata[mc_pkg::IRQ_W-1:0];
                    end
                    default: begin
                        s_d.busWrite = 1'b0;
                    end
                endcase
            end
        end
        if (addrTaken) begin
            s_d.busPhase = mc_pkg::BUS_WAIT;
            s_d.busWrite = hwrite;
            s_d.busAddr = haddr[mc_pkg::ADDR_W-1:0];
        end
        // Machine check events; the stop state freezes all of them
        if (!s_q.stop) begin
            if (stopHit) begin
                s_d.stop = 1'b1;
                s_d.irqStat[mc_pkg::IRQ_STOP] = 1'b1;
            end else if (sysDamage && s_q.pswMc && !s_q.busy) begin
                s_d.code = 32'h0;
                s_d.code[mc_pkg::CODE_SD] = 1'b1;
                s_d.code[mc_pkg::CODE_SE] = err.storageMultiBit;
                s_d.code[mc_pkg::CODE_KE] = err.keyFail;
                s_d.busy = 1'b1;
                s_d.mcHard = 1'b1;
                s_d.logoutReq = s_q.ctl[mc_pkg::CTL_XLOG];
                s_d.irqStat[mc_pkg::IRQ_HARD] = 1'b1;
            end else if ((softRecov || softExt) && !s_q.busy) begin
                s_d.code = 32'h0;
                s_d.code[mc_pkg::CODE_SR] = softRecov;
                s_d.code[mc_pkg::CODE_CD] = softExt & err.todDamage;
                s_d.code[mc_pkg::CODE_ED] = softExt & err.ioMultiBit;
                s_d.busy = 1'b1;
                s_d.mcSoft = 1'b1;
                s_d.irqStat[mc_pkg::IRQ_SOFT] = 1'b1;
            end
        end
        // Program load restores the reset masks but arms status bit 13
        if (initialProgramLoad) begin
            s_d.ctl = mc_pkg::CTL_RESET;
            s_d.logBase = mc_pkg::CR15_RESET;
            s_d.pswMc = mc_pkg::PSW_MC_LOAD;
            s_d.code = 32'h0;
            s_d.busy = 1'b0;
            s_d.stop = 1'b0;
            s_d.logoutReq = 1'b0;
            s_d.mcSoft = 1'b0;
            s_d.mcHard = 1'b0;
        end
    end

    // State register; reset sets the documented mask state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q <= mc_pkg::STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Bus answers: one wait state, always OKAY
    assign hreadyout = (s_q.busPhase != mc_pkg::BUS_WAIT);
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;

    // Fetch steering; with the cache off it is bypassed entirely
    assign fetchToCache = fetchReq & ~s_q.mode[mc_pkg::MODE_CACHE_OFF];
    assign fetchToMain = fetchReq & s_q.mode[mc_pkg::MODE_CACHE_OFF];

    // Result outputs
    assign hardStop = s_q.stop;
    assign retryEnable = s_q.ctl[mc_pkg::CTL_RETRY];
    assign channelLogoutEnable = s_q.ctl[mc_pkg::CTL_CHLOG];
    assign mcSoft = s_q.mcSoft;
    assign mcHard = s_q.mcHard;
    assign logoutReq = s_q.logoutReq & ~s_q.stop;
    assign logoutAddr = s_q.logBase;
    assign irq = |(s_q.irqStat & s_q.irqEn);

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_stop_entry: assert property (stopHit && !hardStop && !initialProgramLoad |=> hardStop)
        else $error("hard stop not entered on masked system damage");
    a_stop_holds: assert property (hardStop && !initialProgramLoad |=> hardStop)
        else $error("hard stop released without load or reset");
    a_stop_cause: assert property ($rose(hardStop) |-> $past(sysDamage))
        else $error("hard stop without a hardware error");
    a_stop_no_logout: assert property (hardStop |-> !logoutReq && !mcHard && !mcSoft)
        else $error("logout or interrupt while stopped");
    a_reset_masks: assert property ($rose(rst_n) |-> s_q.ctl == mc_pkg::CTL_RESET
        && s_q.logBase == mc_pkg::CR15_RESET && !s_q.pswMc && !hardStop)
        else $error("wrong mask state after reset");
    a_reset_ext_on: assert property ($rose(rst_n) |-> s_q.ctl[mc_pkg::CTL_EXTDMG]
        && s_q.ctl[mc_pkg::CTL_HSTOP] && !channelLogoutEnable && !retryEnable)
        else $error("reset enables wrong");
    a_cache_bypass: assert property (s_q.mode[mc_pkg::MODE_CACHE_OFF] && fetchReq
        |-> fetchToMain && !fetchToCache)
        else $error("fetch reached a disabled cache");
    a_quiet_corr: assert property (err.corrected && s_q.mode[mc_pkg::MODE_QUIET_CORR]
        && !err.retryOk && !err.todDamage && !err.ioMultiBit |=> !mcSoft)
        else $error("quiet correction still reported");
    a_recov_mask: assert property (!s_q.ctl[mc_pkg::CTL_RECOV] && !err.todDamage
        && !err.ioMultiBit |=> !mcSoft)
        else $error("recovery report with mask off");
    a_ext_gate: assert property (mcSoft && $past(!softRecov)
        |-> $past(s_q.pswMc && s_q.ctl[mc_pkg::CTL_EXTDMG]))
        else $error("external damage reported while masked");
    a_hard_code: assert property (mcHard |-> s_q.code[mc_pkg::CODE_SD] && s_q.busy
        && s_q.code[mc_pkg::CODE_KE] == $past(err.keyFail))
        else $error("hard check code wrong");
    a_bus_wait: assert property (addrTaken |=> !hreadyout ##1 hreadyout)
        else $error("bus wait state wrong");

    // Program load must restore the masks and release a halted machine
    a_load_masks: assert property (initialProgramLoad |=> s_q.ctl == mc_pkg::CTL_RESET
        && s_q.pswMc && !hardStop && s_q.logBase == mc_pkg::CR15_RESET)
        else $error("mask state wrong after program load");
    // A logout only ever travels with a hard check
    a_logout_with_hard: assert property (logoutReq |-> mcHard)
        else $error("logout without a hard check");
    // A check in hand drops every later report until the handler is done
    a_busy_drops_soft: assert property (s_q.busy && !initialProgramLoad
        |=> !mcSoft && !mcHard)
        else $error("report taken while a check was in hand");
    // Set beats a clear of the same cycle, so the hard bit must be up
    a_hard_irq_sticky: assert property (mcHard |-> s_q.irqStat[mc_pkg::IRQ_HARD])
        else $error("hard check without its status bit");
    // Halted machine refuses every register write
    a_stop_freeze: assert property (hardStop && !initialProgramLoad
        |=> $stable(s_q.ctl) && $stable(s_q.pswMc) && $stable(s_q.logBase))
        else $error("register changed while halted");
    // Hard checks only pass while status bit 13 is set
    a_hard_needs_mask: assert property (mcHard |-> $past(s_q.pswMc))
        else $error("hard check taken with status mask clear");
    // Clock damage code bit only from a clock damage event
    a_clock_code: assert property (mcSoft && s_q.code[mc_pkg::CODE_CD]
        |-> $past(err.todDamage))
        else $error("clock damage code without clock damage");

    c_hard_check: cover property (mcHard);
    c_soft_check: cover property (mcSoft ##[1:20] mcHard);
    c_hard_stop: cover property ($rose(hardStop));
    c_load_release: cover property (hardStop ##1 initialProgramLoad ##1 !hardStop);
    c_quiet_soft: cover property (s_q.mode[mc_pkg::MODE_QUIET_CORR] && mcSoft);

endmodule

// ### machine_check_stop_control_bench.sv
`timescale 1ns/10ps
module machine_check_stop_control_bench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, fetchToCache, fetchToMain, hardStop, retryEnable;
    logic channelLogoutEnable, mcSoft, mcHard, logoutReq, irq;
    logic [31:0] hrdata, logoutAddr;
    mc_pkg::errors_t err = '0;
    logic initialProgramLoad = 1'b0;
    logic fetchReq = 1'b0;
    int miscompares = 0;
    int checks_done = 0;
    int seed = 32'hd16bd799;
    // Reference state kept by the bench, updated from every bus write taken while not halted and every event
    logic [5:0] mCtl = 6'h1c;
    logic [2:0] mIrq = 3'h0;
    logic [2:0] mEn = 3'h0;
    logic [1:0] mMode = 2'h0;
    logic mPsw = 1'b0;
    logic mBusy = 1'b0;
    logic mStop = 1'b0;
    logic [31:0] d;
    logic [31:0] r;

    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    machine_check_stop_control i_machine_check_stop_control (
        .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .err(err),
        .initialProgramLoad(initialProgramLoad), .fetchReq(fetchReq),
        .fetchToCache(fetchToCache), .fetchToMain(fetchToMain), .hardStop(hardStop),
        .retryEnable(retryEnable), .channelLogoutEnable(channelLogoutEnable),
        .mcSoft(mcSoft), .mcHard(mcHard), .logoutReq(logoutReq),
        .logoutAddr(logoutAddr), .irq(irq)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One single-word transfer; waits on hready with no fixed latency assumed
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk(hresp, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        bus(1'b0, a, 32'h0, v);
    endtask

    // Writes are ignored by the block once halted, so the model ignores them too
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        bus(1'b1, a, v, x);
        if (!mStop) begin
            case (a)
                mc_pkg::OFF_CTL14: mCtl = v[5:0];
                mc_pkg::OFF_PSW: mPsw = v[13];
                mc_pkg::OFF_MODE: mMode = v[1:0];
                mc_pkg::OFF_CODE: mBusy = 1'b0;
                mc_pkg::OFF_IRQ_EN: mEn = v[2:0];
                mc_pkg::OFF_IRQ_CLR: mIrq = mIrq & ~v[2:0];
                default: ;
            endcase
        end
    endtask

    task automatic initial_program_load;
        initialProgramLoad <= 1'b1;
        @(posedge ref_clk);
        initialProgramLoad <= 1'b0;
        #1;
        mCtl = 6'h1c;
        mPsw = 1'b1;
        mBusy = 1'b0;
        mStop = 1'b0;
        chk(hardStop, 32'h0);
    endtask

    // Pulse one error kind, compare outputs with the model, then inspect the code
    task automatic ev(input logic [7:0] v, input int keep);
        logic sd, sf, hs, hd, so;
        int b;
        logic [31:0] c;
        err <= mc_pkg::errors_t'(v);
        @(posedge ref_clk);
        err <= '0;
        #1;
        sd = v[2] | v[1] | v[0] | (v[3] & ~mCtl[0]);
        sf = (mCtl[1] & ((v[7] & mCtl[0]) | (v[6] & ~mMode[0])))
            | (mPsw & mCtl[2] & (v[5] | v[4]));
        hs = !mStop && sd && (mBusy || !mPsw) && mCtl[3];
        hd = !mStop && sd && !mBusy && mPsw;
        so = !mStop && !sd && sf && !mBusy;
        chk(hardStop, mStop | hs);
        chk(mcHard, hd);
        chk(logoutReq, hd & mCtl[4]);
        chk(mcSoft, so);
        mStop = mStop | hs;
        mBusy = mBusy | hd | so;
        mIrq = mIrq | {hs, hd, so};
        chk(irq, |(mIrq & mEn));
        if (hd || so) begin
            b = v[0] ? mc_pkg::CODE_KE : v[1] ? mc_pkg::CODE_SE : v[5] ? mc_pkg::CODE_CD :
                v[4] ? mc_pkg::CODE_ED : hd ? mc_pkg::CODE_SD : -1;
            rd(mc_pkg::OFF_CODE, c);
            if (hd) chk(c[mc_pkg::CODE_SD], 32'h1);
            if (b >= 0) chk(c[b], 32'h1);
            if (so && b < 0) chk(c[mc_pkg::CODE_SR], 32'h1);
            if (keep == 0) wr(mc_pkg::OFF_CODE, 32'h0);
        end
    endtask

    // Watchdog sized well above the expected run of under two hundred cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(mc_pkg::OFF_CTL14, d);
        chk(d, 32'h1c);
        chk(retryEnable, 32'h0);
        chk(channelLogoutEnable, 32'h0);
        rd(mc_pkg::OFF_CTL15, d);
        chk(d, 32'h200);
        chk(logoutAddr, 32'h200);
        rd(mc_pkg::OFF_PSW, d);
        chk(d, 32'h0);
        wr(mc_pkg::OFF_IRQ_EN, 32'h7);
        ev(8'h40, 0);
        ev(8'h20, 0);
        // Damage with the status mask clear: halt, no logout, and it sticks
        ev(8'h01, 0);
        wr(mc_pkg::OFF_CTL14, 32'h0);
        rd(mc_pkg::OFF_CTL14, d);
        chk(d, {26'h0, mCtl});
        chk(hardStop, 32'h1);
        initial_program_load();
        rd(mc_pkg::OFF_PSW, d);
        chk(d, 32'h2000);
        wr(mc_pkg::OFF_IRQ_CLR, 32'h7);
        chk(irq, 32'h0);
        // Every system damage kind, retry left disabled after load
        ev(8'h08, 0);
        ev(8'h04, 0);
        ev(8'h02, 0);
        ev(8'h01, 0);
        // Damage while a previous check is still pending
        ev(8'h01, 1);
        ev(8'h02, 0);
        initial_program_load();
        wr(mc_pkg::OFF_CTL14, 32'h1f);
        chk(retryEnable, 32'h1);
        ev(8'h80, 0);
        ev(8'h40, 0);
        ev(8'h20, 0);
        ev(8'h10, 0);
        wr(mc_pkg::OFF_MODE, 32'h1);
        ev(8'h40, 0);
        ev(8'h80, 0);
        wr(mc_pkg::OFF_CTL14, 32'h1d);
        ev(8'h80, 0);
        ev(8'h40, 0);
        ev(8'h20, 0);
        wr(mc_pkg::OFF_CTL14, 32'h19);
        ev(8'h10, 0);
        // Cache disabled: all fetches steered to main storage
        wr(mc_pkg::OFF_MODE, 32'h2);
        repeat (8) begin
            fetchReq <= 1'($random(seed));
            @(posedge ref_clk);
            #1;
            chk(fetchToMain, fetchReq);
            chk(fetchToCache, 32'h0);
        end
        wr(mc_pkg::OFF_MODE, 32'h0);
        #1;
        chk(fetchToCache, fetchReq);
        d = $random(seed);
        wr(mc_pkg::OFF_CTL15, d);
        rd(mc_pkg::OFF_CTL15, r);
        chk(r, d);
        chk(logoutAddr, d);
        rd(8'h40, d);
        chk(d, 32'h0);
        wrap_up();
    end
endmodule

// ### mc_pkg.sv
package mc_pkg;

    // Register byte offsets on the bus
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTL14 = 8'h00;
    localparam logic [7:0] OFF_CTL15 = 8'h04;
    localparam logic [7:0] OFF_PSW = 8'h08;
    localparam logic [7:0] OFF_MODE = 8'h0c;
    localparam logic [7:0] OFF_CODE = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFF_IRQ_EN = 8'h1c;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h20;

    // Machine check mask bits of control register 14
    localparam int CTL_W = 6;
    localparam int CTL_RETRY = 0;
    localparam int CTL_RECOV = 1;
    localparam int CTL_EXTDMG = 2;
    localparam int CTL_HSTOP = 3;
    localparam int CTL_XLOG = 4;
    localparam int CTL_CHLOG = 5;
    localparam logic [5:0] CTL_RESET = 6'h1c;
    localparam logic [31:0] CR15_RESET = 32'h0000_0200;

    // Status word machine check mask and mode bits
    localparam int PSW_MC_BIT = 13;
    localparam logic PSW_MC_RESET = 1'b0;
    localparam logic PSW_MC_LOAD = 1'b1;
    localparam int MODE_QUIET_CORR = 0;
    localparam int MODE_CACHE_OFF = 1;

    // Stored machine check code bits
    localparam int CODE_SD = 0;
    localparam int CODE_SR = 2;
    localparam int CODE_CD = 4;
    localparam int CODE_ED = 5;
    localparam int CODE_SE = 16;
    localparam int CODE_KE = 18;

    // Block status and interrupt bits
    localparam int STAT_STOP = 0;
    localparam int STAT_BUSY = 1;
    localparam int STAT_BYPASS = 2;
    localparam int IRQ_W = 3;
    localparam int IRQ_SOFT = 0;
    localparam int IRQ_HARD = 1;
    localparam int IRQ_STOP = 2;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_WAIT = 2'b10
    } bus_phase_t;

    // Detected hardware errors, one-cycle pulses
    typedef struct packed {
        logic retryOk;
        logic corrected;
        logic todDamage;
        logic ioMultiBit;
        logic cpuError;
        logic cpuUnretryable;
        logic storageMultiBit;
        logic keyFail;
    } errors_t;

    typedef struct packed {
        logic [CTL_W-1:0] ctl;
        logic [31:0] logBase;
        logic pswMc;
        logic [1:0] mode;
        logic [31:0] code;
        logic busy;
        logic stop;
        logic [IRQ_W-1:0] irqStat;
        logic [IRQ_W-1:0] irqEn;
        bus_phase_t busPhase;
        logic busWrite;
        logic [ADDR_W-1:0] busAddr;
        logic [31:0] rdata;
        logic logoutReq;
        logic mcSoft;
        logic mcHard;
    } state_t;

    localparam state_t STATE_RESET = '{
        ctl: CTL_RESET, logBase: CR15_RESET, pswMc: PSW_MC_RESET, mode: 2'h0,
        code: 32'h0, busy: 1'b0, stop: 1'b0, irqStat: 3'h0, irqEn: 3'h0,
        busPhase: BUS_IDLE, busWrite: 1'b0, busAddr: 8'h00, rdata: 32'h0,
        logoutReq: 1'b0, mcSoft: 1'b0, mcHard: 1'b0
    };

endpackage
